// file: hdl/csd_clock_control.v
// Summary of operation
// - Clock output runs at half CPU rate
// - Clock output only when crystal unused
// - Trim register enable bit gates output
// - Six-bit trim, factory reset value, writable
// - Config bit three enables RC doubler
// - Low-power bit cleared on reset
// - Crystal sources wait 992 cycles plus
// - Other sources wait 224 cycles plus
// - Divider reduces rate up to 510
// - New divider taken without stalling CPU
// - External mode releases crystal output pin
// - Watchdog oscillator selectable as source
//
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "csd_defines.vh"
module csd_clock_control #(
	parameter [15:0] WAKE_EXTRA_CYC = `CSD_WAKE_EXTRA_NS / `CSD_CLK_PERIOD_NS,
	parameter [5:0] FACTORY_TRIM = `CSD_TRIM_RST
) (
	input wire sys_clk, // System clock, 125 MHz
	input wire reset_n, // Synchronous reset, active low
	input wire wb_cyc_i, // Bus cycle
	input wire wb_stb_i, // Bus strobe
	input wire wb_we_i, // Write enable
	input wire [3:0] wb_adr_i, // Byte address
	input wire [3:0] wb_sel_i, // Byte lanes
	input wire [31:0] wb_dat_i, // Write data
	output reg [31:0] wb_dat_o, // Read data
	output reg wb_ack_o, // Acknowledge
	input wire [7:0] user_config_byte_one, // Configuration byte
	input wire rtc_uses_crystal, // RTC runs from crystal
	input wire oscillator_clock, // One pulse per oscillator cycle
	output reg cpu_clock, // CPU clock pulse
	output reg clock_output_pin, // Clock output level
	output reg clock_output_pin_oe_n, // Pin drive, low drives
	output reg crystal_output_release, // Crystal out free for port use
	output reg [5:0] rc_trim_value, // Trim to RC oscillator
	output reg rc_doubler_enable, // RC doubler on
	output reg watchdog_osc_select, // Watchdog oscillator in use
	output reg low_power_clock_select, // Low-power access bit
	output reg wake_done // Wake-up delay over
);

	// Software-visible register state
	reg [5:0] trim_ff; // RC trim value
	reg [5:0] nxt_trim;
	reg clkoe_ff; // Clock output enable bit
	reg nxt_clkoe;
	reg [7:0] div_ff; // Divider value
	reg [7:0] nxt_div;
	reg lpsel_ff; // Low-power bit
	reg nxt_lpsel;
	reg ack_ff; // Bus acknowledge
	reg [31:0] rdat_ff; // Read data
	reg [31:0] nxt_rdat;
	// Wake-up timer and divider state
	reg [1:0] wstate_ff; // Wake-up state
	reg [1:0] nxt_wstate;
	reg [15:0] wcnt_ff; // Wake-up counter
	reg [15:0] nxt_wcnt;
	reg [8:0] dcnt_ff; // Divider counter
	reg [8:0] nxt_dcnt;
	reg cpu_ff; // CPU clock pulse
	reg cko_ff; // Clock output level
	reg nxt_cko;
	// Strap copies stay frozen until the next reset, so a late config
	// change cannot switch sources under a running CPU
	reg [2:0] src_ff; // Source latched after reset
	reg dbl_ff; // Doubler latched after reset
	reg strap_ff; // Config caught once after reset

	wire bus_req; // Request present
	wire bus_wr; // Write taken at ack edge
	wire xtal_src; // Crystal source selected
	wire cko_allowed; // Crystal not in use
	wire [8:0] div_last; // Last count of a CPU period

	// Wake-up timer states, binary coded
	localparam [1:0] WS_OSC = 2'd0; // Counting oscillator cycles
	localparam [1:0] WS_EXTRA = 2'd1; // Counting settle time
	localparam [1:0] WS_RUN = 2'd2; // CPU clock running

	// Crystal source test
	function is_xtal;
		input [2:0] src;
		begin
			is_xtal = (src == `CSD_SRC_XLOW) || (src == `CSD_SRC_XMED) ||
				(src == `CSD_SRC_XHIGH);
		end
	endfunction

	assign bus_req = wb_cyc_i & wb_stb_i;
	// Write lands on the edge where the master sees ack
	assign bus_wr = bus_req & wb_we_i & ack_ff & wb_sel_i[0];
	assign xtal_src = is_xtal(src_ff);
	assign cko_allowed = ~xtal_src & ~rtc_uses_crystal;
	assign div_last = {div_ff, 1'b0} - 9'h001;

	// Configuration strap capture, taken after reset release
	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			src_ff <= `CSD_SRC_RC;
			dbl_ff <= 1'b0;
			strap_ff <= 1'b0;
		end
		else if (!strap_ff)
		begin
			src_ff <= user_config_byte_one[2:0];
			dbl_ff <= user_config_byte_one[`CSD_DBL_BIT];
			strap_ff <= 1'b1;
		end
	end

	// Register writes
	always @*
	begin
		nxt_trim = trim_ff;
		nxt_clkoe = clkoe_ff;
		nxt_div = div_ff;
		nxt_lpsel = lpsel_ff;
		if (bus_wr)
		begin
			case (wb_adr_i)
				`CSD_TRIM_OFS:
				begin
					nxt_trim = wb_dat_i[5:0];
					nxt_clkoe = wb_dat_i[`CSD_CLKOE_BIT];
				end
				`CSD_DIV_OFS: nxt_div = wb_dat_i[7:0];
				// Software sets it only at 8 MHz or below
				// No rate check in hardware, kept cheap
				`CSD_AUX_OFS: nxt_lpsel = wb_dat_i[`CSD_LPSEL_BIT];
				default: nxt_trim = trim_ff;
			endcase
		end
	end

	// Read mux, unmapped reads give zero
	// Status word shows strap and wake-up progress
	always @*
	begin
		nxt_rdat = 32'h00000000;
		case (wb_adr_i)
			`CSD_TRIM_OFS: nxt_rdat = {25'h0, clkoe_ff, trim_ff};
			`CSD_DIV_OFS: nxt_rdat = {24'h0, div_ff};
			`CSD_AUX_OFS: nxt_rdat = {24'h0, lpsel_ff, 7'h00};
			`CSD_STAT_OFS: nxt_rdat = {24'h0, cko_allowed, dbl_ff,
				wstate_ff == WS_RUN, src_ff, wstate_ff};
			default: nxt_rdat = 32'h00000000;
		endcase
	end

	// Register storage and bus handshake
	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			trim_ff <= FACTORY_TRIM;
			clkoe_ff <= 1'b0;
			div_ff <= `CSD_DIV_RST;
			lpsel_ff <= 1'b0;
			ack_ff <= 1'b0;
			rdat_ff <= 32'h00000000;
		end
		else
		begin
			trim_ff <= nxt_trim;
			clkoe_ff <= nxt_clkoe;
			div_ff <= nxt_div;
			lpsel_ff <= nxt_lpsel;
			// One ack per request, dropped the cycle after
			ack_ff <= bus_req & ~ack_ff;
			rdat_ff <= nxt_rdat;
		end
	end

	// Wake-up timer next state
	always @*
	begin
		nxt_wstate = wstate_ff;
		nxt_wcnt = wcnt_ff;
		case (wstate_ff)
			WS_OSC:
			begin
				if (strap_ff && oscillator_clock)
				begin
					if (wcnt_ff == (xtal_src ? {6'h0, `CSD_WAKE_XTAL} - 16'h0001 :
						{6'h0, `CSD_WAKE_OTHER} - 16'h0001))
					begin
						nxt_wstate = WS_EXTRA;
						nxt_wcnt = 16'h0000;
					end
					else
						nxt_wcnt = wcnt_ff + 16'h0001;
				end
			end
			WS_EXTRA:
			begin
				// Settle time counted on the system clock, osc may be slow
				if (wcnt_ff >= WAKE_EXTRA_CYC - 16'h0001)
					nxt_wstate = WS_RUN;
				else
					nxt_wcnt = wcnt_ff + 16'h0001;
			end
			WS_RUN: nxt_wstate = WS_RUN;
			default: nxt_wstate = WS_OSC;
		endcase
	end

	// Divider next state
	always @*
	begin
		nxt_dcnt = dcnt_ff;
		nxt_cko = cko_ff;
		if (wstate_ff == WS_RUN && oscillator_clock)
		begin
			// A shrunken value ends the period at the next osc pulse,
			// so the CPU never sees a stretched or missing period
			// count up to 510
			if (div_ff == 8'h00 || dcnt_ff >= div_last)
			begin
				nxt_dcnt = 9'h000;
				nxt_cko = ~cko_ff;
			end
			else
				nxt_dcnt = dcnt_ff + 9'h001;
		end
	end

	// Wake-up and divider state
	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			wstate_ff <= WS_OSC;
			wcnt_ff <= 16'h0000;
			dcnt_ff <= 9'h000;
			cpu_ff <= 1'b0;
			cko_ff <= 1'b0;
		end
		else
		begin
			wstate_ff <= nxt_wstate;
			wcnt_ff <= nxt_wcnt;
			dcnt_ff <= nxt_dcnt;
			// CPU pulse only when the period completes
			cpu_ff <= (nxt_cko != cko_ff);
			cko_ff <= nxt_cko;
		end
	end

	// Registered outputs
	// Pin parked low, driver off, whenever output is refused
	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			clock_output_pin <= 1'b0;
			clock_output_pin_oe_n <= 1'b1;
			crystal_output_release <= 1'b0;
			watchdog_osc_select <= 1'b0;
		end
		else
		begin
			clock_output_pin <= cko_ff & clkoe_ff & cko_allowed;
			clock_output_pin_oe_n <= ~(clkoe_ff & cko_allowed);
			crystal_output_release <= (src_ff == `CSD_SRC_EXT) ||
				(src_ff == `CSD_SRC_RC) || (src_ff == `CSD_SRC_WDOG);
			watchdog_osc_select <= (src_ff == `CSD_SRC_WDOG);
		end
	end

	// Output copies of state
	always @*
	begin
		wb_dat_o = rdat_ff;
		wb_ack_o = ack_ff;
		cpu_clock = cpu_ff;
		rc_trim_value = trim_ff;
		rc_doubler_enable = dbl_ff;
		low_power_clock_select = lpsel_ff;
		wake_done = (wstate_ff == WS_RUN);
	end

endmodule
`default_nettype wire

// file: hdl/csd_defines.vh
`ifndef CSD_DEFINES_VH
`define CSD_DEFINES_VH
// Register byte offsets
`define CSD_TRIM_OFS 4'h0
`define CSD_DIV_OFS 4'h4
`define CSD_AUX_OFS 4'h8
`define CSD_STAT_OFS 4'hc
// Field positions
`define CSD_CLKOE_BIT 6
`define CSD_LPSEL_BIT 7
`define CSD_DBL_BIT 3
// Reset values
`define CSD_TRIM_RST 6'h20
`define CSD_DIV_RST 8'h00
// Source encodings in config bits [2:0]
`define CSD_SRC_XLOW 3'h0
`define CSD_SRC_XMED 3'h1
`define CSD_SRC_XHIGH 3'h2
`define CSD_SRC_RC 3'h3
`define CSD_SRC_WDOG 3'h4
`define CSD_SRC_EXT 3'h7
// Wake-up timing
`define CSD_WAKE_XTAL 10'd992
`define CSD_WAKE_OTHER 10'd224
`define CSD_WAKE_EXTRA_NS 60000
`define CSD_CLK_PERIOD_NS 8
`endif

// file: tb/csd_checker.sv
`timescale 1ns/1ps
`default_nettype none
module csd_checker (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic rtc_uses_crystal,
	input wire logic oscillator_clock,
	input wire logic cpu_clock,
	input wire logic clock_output_pin,
	input wire logic clock_output_pin_oe_n,
	input wire logic crystal_output_release,
	input wire logic watchdog_osc_select,
	input wire logic low_power_clock_select,
	input wire logic wake_done
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	// Request not yet answered
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	property p_ack; s_req |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_one: assert property (p_one) else $error("long ack");
	property p_gate; !wake_done |-> !cpu_clock; endproperty
	a_gate: assert property (p_gate) else $error("early cpu");
	property p_src; cpu_clock |-> $past(oscillator_clock); endproperty
	a_src: assert property (p_src) else $error("stray cpu");
	// Pin may only move right after a CPU period ends
	property p_half; !clock_output_pin_oe_n && !$past(clock_output_pin_oe_n)
		&& $changed(clock_output_pin) |-> $past(cpu_clock); endproperty
	a_half: assert property (p_half) else $error("bad toggle");
	property p_rtc; rtc_uses_crystal [*3] |-> clock_output_pin_oe_n; endproperty
	a_rtc: assert property (p_rtc) else $error("pin driven");
	property p_lp; $rose(reset_n) |-> !low_power_clock_select; endproperty
	a_lp: assert property (p_lp) else $error("lp set");
	property p_wd; watchdog_osc_select |-> crystal_output_release; endproperty
	a_wd: assert property (p_wd) else $error("pin held");
endmodule
`default_nettype wire

// file: tb/csd_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module csd_osc_model (
	input wire logic sys_clk, // Clock
	input wire logic [3:0] gap, // Idle cycles
	output logic oscillator_clock // Osc pulse
);
	logic [3:0] cnt_ff = 4'h0; // Gap count
	always @(posedge sys_clk)
	begin
		oscillator_clock <= cnt_ff == gap;
		cnt_ff <= (cnt_ff == gap) ? 4'h0 : cnt_ff + 4'h1;
	end
endmodule
`default_nettype wire

// file: tb/clock_source_divider_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module clock_source_divider_control_test;
	logic sys_clk = 1'b0, reset_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic rtc_uses_crystal = 1'b0, oscillator_clock, cpu_clock, clock_output_pin, wb_ack_o;
	logic clock_output_pin_oe_n, crystal_output_release, rc_doubler_enable, wake_done;
	logic watchdog_osc_select, low_power_clock_select;
	// Osc pulse every 7 cycles, about 17.9 MHz
	logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf, gap = 4'h6;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
	logic [7:0] user_config_byte_one = 8'h0;
	logic [5:0] rc_trim_value;
	integer fail_count = 0, checks_done = 0, cyc_n = 0, seed = 32'h8ec9339c, n, i, t;
	integer cpu_n = 0, c;
	csd_clock_control #(.WAKE_EXTRA_CYC(16'h0004)) csd_clock_control_inst (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.user_config_byte_one(user_config_byte_one),
		.rtc_uses_crystal(rtc_uses_crystal),
		.oscillator_clock(oscillator_clock),
		.cpu_clock(cpu_clock),
		.clock_output_pin(clock_output_pin),
		.clock_output_pin_oe_n(clock_output_pin_oe_n),
		.crystal_output_release(crystal_output_release),
		.rc_trim_value(rc_trim_value),
		.rc_doubler_enable(rc_doubler_enable),
		.watchdog_osc_select(watchdog_osc_select),
		.low_power_clock_select(low_power_clock_select),
		.wake_done(wake_done)
	);
	csd_osc_model csd_osc_model_inst (
		.sys_clk(sys_clk),
		.gap(gap),
		.oscillator_clock(oscillator_clock)
	);
	always #4 sys_clk = ~sys_clk;
	// CPU pulse count, unknowns before reset ignored
	always @(posedge sys_clk)
	begin
		if (cpu_clock === 1'b1)
			cpu_n <= cpu_n + 1;
	end
	// Cycle count, hang guard
	always @(posedge sys_clk)
	begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 90000)
		begin
			fail_count++;
			stop_test;
		end
	end
	task stop_test;
	begin
		if (fail_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask
	task chk(input logic [31:0] g, e);
	begin
		checks_done++;
		if (g !== e)
		begin
			fail_count++;
			$display("[ERR] %0t %h %h", $time, g, e);
		end
	end
	endtask
	// One classic cycle; on a read d is the expected data
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
	begin
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(posedge sys_clk);
		while (wb_ack_o !== 1'b1)
			@(posedge sys_clk);
		if (!w)
			chk(wb_dat_o, d);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge sys_clk);
	end
	endtask
	// Wait for a rising edge on the clock output
	task rise;
	begin
		while (clock_output_pin !== 1'b0)
			@(posedge sys_clk);
		while (clock_output_pin !== 1'b1)
			@(posedge sys_clk);
	end
	endtask
	initial
	begin
		// Every source, each after a fresh reset
		for (t = 0; t < 6; t++)
		begin
			r = $random(seed);
			reset_n <= 1'b0;
			user_config_byte_one <= {4'h0, r[0], (t == 5) ? 3'h7 : t[2:0]};
			repeat (5) @(posedge sys_clk);
			// osc above 12 MHz, reset input kept in use
			reset_n <= 1'b1;
			n = 0;
			while (wake_done !== 1'b1)
			begin
				@(posedge sys_clk);
				n += oscillator_clock;
			end
			n -= (t < 3) ? 992 : 224;
			chk(n >= 0 && n < 5, 1'h1);
			chk(rc_doubler_enable, r[0]);
			chk(crystal_output_release, t > 2);
			chk(watchdog_osc_select, t == 4);
			chk(rc_trim_value, 6'h20);
		end
		bus(1, 4'h0, {25'h0, 1'b1, r[5:0]});
		bus(0, 4'h0, {25'h0, 1'b1, r[5:0]});
		chk(clock_output_pin_oe_n, 1'h0);
		bus(0, 4'h2, 32'h0);
		bus(1, 4'h8, 32'h80);
		bus(0, 4'h8, 32'h80);
		// Divider values, the last one the largest
		for (i = 0; i < 4; i++)
		begin
			n = (i == 3) ? 255 : i;
			bus(1, 4'h4, n);
			rise;
			rise;
			t = cyc_n;
			c = cpu_n;
			rise;
			chk(cyc_n - t, (gap + 1) * ((n == 0) ? 2 : 4 * n));
			chk(cpu_n - c, 2);
		end
		bus(1, 4'h0, 32'h0);
		repeat (3) @(posedge sys_clk);
		chk(clock_output_pin_oe_n, 1'h1);
		bus(1, 4'h0, 32'h40);
		rtc_uses_crystal <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk(clock_output_pin_oe_n, 1'h1);
		// Low-power bit and trim return to reset values
		reset_n <= 1'b0;
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		chk(low_power_clock_select, 1'h0);
		chk(rc_trim_value, 6'h20);
		chk(clock_output_pin_oe_n, 1'h1);
		stop_test;
	end
endmodule
bind csd_clock_control csd_checker csd_checker_inst (
	.sys_clk(sys_clk),
	.reset_n(reset_n),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o),
	.rtc_uses_crystal(rtc_uses_crystal),
	.oscillator_clock(oscillator_clock),
	.cpu_clock(cpu_clock),
	.clock_output_pin(clock_output_pin),
	.clock_output_pin_oe_n(clock_output_pin_oe_n),
	.crystal_output_release(crystal_output_release),
	.watchdog_osc_select(watchdog_osc_select),
	.low_power_clock_select(low_power_clock_select),
	.wake_done(wake_done)
);
`default_nettype wire
